// >>> rtl/cmf_consts.vh
// Constants for the configurable macrocell fabric.
// Assumes inclusion by rtl/cmf_fabric.v only.
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH
`define CMF_NUM_MC 64
`define CMF_NUM_IO 32
`define CMF_NUM_DED 4
`define CMF_NUM_PT 5
`define CMF_MC_PER_BLK 16
`define CMF_NUM_BLK 4
`define CMF_SEL_PER_BLK 40
`define CMF_GBUS_W 100
`define CMF_LIT_W 88
`define CMF_REG_WORDS 1024
// Register map, byte offsets
`define CMF_ADDR_CFG_BASE 32'h00000000
`define CMF_ADDR_PTLIT_BASE 32'h00004000
`define CMF_ADDR_SWM_BASE 32'h00002000
`define CMF_ADDR_SIG 32'h00003000
`define CMF_ADDR_FUSE 32'h00003004
`define CMF_ADDR_STATE 32'h00003008
`define CMF_ADDR_PIN_IN 32'h0000300C
// Per-macrocell config word fields
`define CMF_F_ROUTE_LO 0
`define CMF_F_ROUTE_HI 4
`define CMF_F_XOR_LO 5
`define CMF_F_XOR_HI 6
`define CMF_F_DSEL_LO 7
`define CMF_F_DSEL_HI 8
`define CMF_F_LATCH 9
`define CMF_F_CKSEL_LO 10
`define CMF_F_CKSEL_HI 12
`define CMF_F_CKEN 13
`define CMF_F_CLR_LO 14
`define CMF_F_CLR_HI 15
`define CMF_F_PRE 16
`define CMF_F_OUTREG 17
`define CMF_F_FBREG 18
`define CMF_F_IOMODE_LO 19
`define CMF_F_IOMODE_HI 20
`define CMF_F_OESEL_LO 21
`define CMF_F_OESEL_HI 23
`define CMF_F_FOLD_LO 24
`define CMF_F_FOLD_HI 26
`define CMF_F_CASEN 27
`define CMF_F_FFMODE_LO 28
`define CMF_F_FFMODE_HI 29
`define CMF_CFG_W 30
`endif

// >>> rtl/cmf_fabric.v
// Macrocell fabric: 64 macrocells, 4 blocks, switch matrices,
// foldback and cascade, all configured over a Wishbone slave.
// Assumes pins are asynchronous and the fabric runs on clk only.
// Functional notes
// - five product terms, each routed by config
// - terms read global and regional buses
// - unrouted terms ORed into one sum
// - cascade chains reach eighty product terms
// - XOR second input term, one, zero
// - XOR supports toggle and JK storage
// - data from XOR, term or pin
// - latch transparent while clock high
// - clock from four globals or term
// - flip-flop updates on rising edge
// - term clock enable gates global clocks
// - clear global, term, both, or off
// - preset term or off
// - output and feedback independently registered
// - pin input, output or bidirectional
// - enable from two pins, pins, macrocells
// - global bus holds pins and feedback
// - block switch picks forty signals
// - inverted foldback term onto regional bus
// - dedicated inputs serve as global controls
// - signature readable despite security fuse
// - flip-flop D, T, JK, SR modes
//
// The Wishbone register port and the register offsets are this design's own decisions.
`include "cmf_consts.vh"
`default_nettype none
module cmf_fabric (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [3:0] ded_in,
  input wire [31:0] io_in,
  output reg [31:0] io_out,
  output reg [31:0] io_oe
);
  // Synchronise all pins
  reg [35:0] pin_s1_r;
  reg [35:0] pin_s2_r;
  always @(posedge clk) begin
    if (!nrst) begin
      pin_s1_r <= 36'h0;
      pin_s2_r <= 36'h0;
    end else begin
      pin_s1_r <= {ded_in, io_in};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire [31:0] io_s = pin_s2_r[31:0];
  wire [3:0] ded_s = pin_s2_r[35:32];

  // Configuration storage
  reg [`CMF_CFG_W-1:0] cfg_r [0:`CMF_NUM_MC-1];
  reg [`CMF_LIT_W-1:0] lit_r [0:`CMF_NUM_MC*`CMF_NUM_PT-1];
  reg [6:0] swm_r [0:`CMF_NUM_BLK*`CMF_SEL_PER_BLK-1];
  reg [15:0] sig_r;
  reg fuse_r;
  reg ack_r;
  reg [`CMF_NUM_MC-1:0] st_r;
  wire [`CMF_NUM_MC-1:0] fb;
  wire [`CMF_NUM_MC-1:0] fold;
  wire [`CMF_NUM_MC-1:0] casc;

  // Global bus: pins then buried feedback
  wire [`CMF_GBUS_W-1:0] gbus = {fb, io_s, ded_s};

  // Wishbone decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr_all = req & wb_we_i & (wb_sel_i == 4'hF);
  wire [31:0] off = wb_adr_i & 32'h00000FFF;
  wire in_cfg = (wb_adr_i[15:12] == 4'h0) && (off[11:2] < 10'd64);
  // Term literals sit in their own 8 KiB window so all 320 terms fit
  wire in_lit = (wb_adr_i[15:13] == 3'b010);
  wire in_swm = (wb_adr_i[15:12] == 4'h2) && (off[11:2] < 10'd160);
  wire [9:0] widx = off[11:2];
  wire [8:0] lterm = wb_adr_i[12:4];
  wire [1:0] lsub = wb_adr_i[3:2];
  wire lit_ok = in_lit && (lterm < 9'd320);

  // Single-cycle ack, cleared next cycle
  always @(posedge clk) begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end
  assign wb_ack_o = ack_r;

  // Register writes; fuse locks config, signature stays open
  always @(posedge clk) begin
    if (!nrst) begin
      sig_r <= 16'h0000;
      fuse_r <= 1'b0;
    end else if (wr_all) begin
      if (wb_adr_i[15:0] == `CMF_ADDR_SIG) sig_r <= wb_dat_i[15:0];
      if (wb_adr_i[15:0] == `CMF_ADDR_FUSE && wb_dat_i[0]) fuse_r <= 1'b1;
    end
  end
  always @(posedge clk) begin
    if (wr_all && !fuse_r) begin
      if (in_cfg) cfg_r[widx[5:0]] <= wb_dat_i[`CMF_CFG_W-1:0];
      if (in_swm) swm_r[widx[7:0]] <= wb_dat_i[6:0];
    end
  end
  // Literal words: 88 bits per term, written as three words of 32, 32 and 24 bits
  always @(posedge clk) begin
    if (wr_all && !fuse_r && lit_ok) begin
      if (lsub == 2'd0) lit_r[lterm][31:0] <= wb_dat_i;
      if (lsub == 2'd1) lit_r[lterm][63:32] <= wb_dat_i;
      if (lsub == 2'd2) lit_r[lterm][87:64] <= wb_dat_i[23:0];
    end
  end

  // Read mux; config hidden when fused, unmapped reads zero
  always @(posedge clk) begin
    if (!nrst)
      wb_dat_o <= 32'h0;
    else if (req && !wb_we_i) begin
      wb_dat_o <= 32'h0;
      if (wb_adr_i[15:0] == `CMF_ADDR_SIG) wb_dat_o <= {16'h0, sig_r};
      else if (wb_adr_i[15:0] == `CMF_ADDR_FUSE) wb_dat_o <= {31'h0, fuse_r};
      else if (wb_adr_i[15:0] == `CMF_ADDR_STATE) wb_dat_o <= st_r[31:0];
      else if (wb_adr_i[15:0] == `CMF_ADDR_STATE + 16'h10) wb_dat_o <= st_r[63:32];
      else if (wb_adr_i[15:0] == `CMF_ADDR_PIN_IN) wb_dat_o <= io_s;
      else if (!fuse_r && in_cfg) wb_dat_o <= {2'b0, cfg_r[widx[5:0]]};
      else if (!fuse_r && in_swm) wb_dat_o <= {25'h0, swm_r[widx[7:0]]};
    end
  end

  // Per-block switch matrix and per-macrocell logic
  genvar b, m, p, k;
  generate
    for (b = 0; b < `CMF_NUM_BLK; b = b + 1) begin : g_blk
      wire [`CMF_SEL_PER_BLK-1:0] swo;
      for (k = 0; k < `CMF_SEL_PER_BLK; k = k + 1) begin : g_sw
        wire [6:0] s = swm_r[b*`CMF_SEL_PER_BLK+k];
        assign swo[k] = (s < 7'd100) ? gbus[s] : 1'b0;
      end
      for (m = 0; m < `CMF_MC_PER_BLK; m = m + 1) begin : g_mc
        localparam integer N = b*`CMF_MC_PER_BLK + m;
        localparam integer R = (N / 4) * 4;
        wire [`CMF_CFG_W-1:0] c = cfg_r[N];
        wire [3:0] rbus = fold[R+3:R];
        wire [43:0] ins = {rbus, swo};
        wire [4:0] pt;
        for (p = 0; p < `CMF_NUM_PT; p = p + 1) begin : g_pt
          wire [87:0] l = lit_r[N*`CMF_NUM_PT+p];
          // AND of selected true/complement literals
          assign pt[p] = &((~l[43:0] | ins) & (~l[87:44] | ~ins));
        end
        // Term routing: bit set sends term to control use
        wire [4:0] route = c[`CMF_F_ROUTE_HI:`CMF_F_ROUTE_LO];
        wire [4:0] sum_pt = pt & ~route;
        // First cell of a block starts a fresh chain
        wire cascade_sum_in;
        if (N % `CMF_MC_PER_BLK == 0) begin : g_c0
          assign cascade_sum_in = 1'b0;
        end else begin : g_cn
          assign cascade_sum_in = casc[N-1];
        end
        wire orsum = (|sum_pt) | cascade_sum_in;
        assign casc[N] = c[`CMF_F_CASEN] & orsum;
        // Control terms: 1=xor 2=data 3=clock/enable 4=clear/preset
        wire xin_sel = c[`CMF_F_XOR_HI:`CMF_F_XOR_LO] == 2'd2;
        wire x2 = (c[`CMF_F_XOR_HI:`CMF_F_XOR_LO] == 2'd1) ? 1'b1 :
                  xin_sel ? pt[1] : 1'b0;
        wire xo = orsum ^ x2;
        wire [1:0] dsel = c[`CMF_F_DSEL_HI:`CMF_F_DSEL_LO];
        wire io_bit = io_s[N % `CMF_NUM_IO];
        wire dval = (dsel == 2'd1) ? pt[2] : (dsel == 2'd2) ? io_bit : xo;
        wire [2:0] cks = c[`CMF_F_CKSEL_HI:`CMF_F_CKSEL_LO];
        wire ckv = (cks == 3'd3) ? pt[3] : (cks == 3'd4) ? ded_s[3] : ded_s[cks[1:0] % 3];
        wire cken = (c[`CMF_F_CKEN] && cks != 3'd3) ? pt[3] : 1'b1;
        wire [1:0] clrs = c[`CMF_F_CLR_HI:`CMF_F_CLR_LO];
        wire clr = (clrs == 2'd1) ? ded_s[3] : (clrs == 2'd2) ? pt[4] :
                   (clrs == 2'd3) ? (ded_s[3] | pt[4]) : 1'b0;
        wire pre = c[`CMF_F_PRE] & pt[4] & ~(clrs[1]);
        reg ck_d_r;
        wire rise = ckv & ~ck_d_r;
        wire q = st_r[N];
        reg nq;
        // Next-state per flip-flop mode
        always @* begin
          case (c[`CMF_F_FFMODE_HI:`CMF_F_FFMODE_LO])
            2'd1: nq = q ^ dval;
            2'd2: nq = (dval & ~q) | (~x2 & q);
            2'd3: nq = x2 ? 1'b0 : (dval ? 1'b1 : q);
            default: nq = dval;
          endcase
        end
        // Storage element with clear over preset
        always @(posedge clk) begin
          if (!nrst) begin
            ck_d_r <= 1'b0;
            st_r[N] <= 1'b0;
          end else begin
            ck_d_r <= ckv;
            if (clr) st_r[N] <= 1'b0;
            else if (pre) st_r[N] <= 1'b1;
            else if (c[`CMF_F_LATCH]) begin
              if (ckv) st_r[N] <= dval;
            end else if (rise && cken) st_r[N] <= nq;
          end
        end
        wire comb = xo;
        assign fb[N] = c[`CMF_F_FBREG] ? q : comb;
        wire outv = c[`CMF_F_OUTREG] ? q : comb;
        assign fold[N] = ~pt[c[`CMF_F_FOLD_HI:`CMF_F_FOLD_LO] % 5];
        if (N < `CMF_NUM_IO) begin : g_io
          wire [2:0] oes = c[`CMF_F_OESEL_HI:`CMF_F_OESEL_LO];
          wire oe_src = (oes == 3'd0) ? ded_s[0] : (oes == 3'd1) ? ~ded_s[0] :
                        (oes == 3'd2) ? ded_s[1] : (oes == 3'd3) ? ~ded_s[1] :
                        (oes == 3'd4) ? io_s[(N+1)%32] : fb[(N+32)%64];
          wire [1:0] iom = c[`CMF_F_IOMODE_HI:`CMF_F_IOMODE_LO];
          // Pin drive; input mode keeps macrocell usable
          always @(posedge clk) begin
            if (!nrst) begin
              io_out[N] <= 1'b0;
              io_oe[N] <= 1'b0;
            end else begin
              io_out[N] <= outv;
              io_oe[N] <= (iom == 2'd1) | ((iom == 2'd2) & oe_src);
            end
          end
        end
      end
    end
  endgenerate
endmodule // cmf_fabric
`default_nettype wire

// >>> verification/cmf_fabric_assertions.sv
// Checker for the fabric bus handshake, reset and read-back values.
// Assumes binding to the cmf_fabric top module ports.
`default_nettype none
module cmf_fabric_chk (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [31:0] io_out,
  input wire [31:0] io_oe
);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  logic rd_unm_r, rd_sig_r, rd_cfg_r, fuse_r;
  // Note the kind of each read taken and the fuse state
  always @(posedge clk) begin
    rd_unm_r <= req && !wb_we_i && wb_adr_i[15:12] > 4'h3;
    rd_sig_r <= req && !wb_we_i && wb_adr_i[15:0] == 16'h3000;
    rd_cfg_r <= req && !wb_we_i && wb_adr_i[15:12] < 4'h3;
    fuse_r <= nrst && (fuse_r || (wb_ack_o && wb_we_i && wb_sel_i == 4'hF
      && wb_adr_i[15:0] == 16'h3004 && wb_dat_i[0]));
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !wb_ack_o && wb_dat_o == 32'h0
    && io_out == 32'h0 && io_oe == 32'h0)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (wb_ack_o && rd_unm_r |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_sig_width: assert property (wb_ack_o && rd_sig_r |-> wb_dat_o[31:16] == 16'h0)
    else $error("signature wider than 16 bits");
  a_fuse_locks: assert property (wb_ack_o && rd_cfg_r && fuse_r |-> wb_dat_o == 32'h0)
    else $error("config readable with fuse set");
  a_dat_hold: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without read");
endmodule // cmf_fabric_chk
bind cmf_fabric cmf_fabric_chk i_cmf_fabric_chk (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .io_out, .io_oe);
`default_nettype wire

// >>> verification/cmf_fabric_tb_top.sv
// Testbench for the macrocell fabric: bus, pin logic and storage.
// Assumes cmf_fabric and its checker are compiled before it.
`default_nettype none
module cmf_fabric_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pin_chk = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, io_in = 32'h0, sig;
  logic [3:0] wb_sel_i = 4'hF, ded_in = 4'h0;
  integer seed = 32'h45BA36BE;
  wire [31:0] wb_dat_o, io_out, io_oe;
  wire wb_ack_o;
  logic [31:0] rd_q[$];
  logic [1:0] pin_q[$];
  int n_errors = 0, tests_run = 0;
  cmf_fabric i_cmf_fabric (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .ded_in, .io_in, .io_out, .io_oe);
  // Clock
  always #5 clk = ~clk;
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t read exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_pin(input logic [1:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t pin exp %h got %h", $time, e, g);
    end
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20)
      n_errors++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  // Pin 1 carries the test value, the rest are random
  task automatic pio(input logic v);
    @(posedge clk);
    io_in <= $random(seed) & 32'hFFFFFFFD | {30'h0, v, 1'b0};
  endtask
  task automatic ded(input logic [3:0] d);
    @(posedge clk);
    ded_in <= d;
    repeat (4) @(posedge clk);
    ded_in <= 4'h0;
  endtask
  // Expects {oe, out} of pin 0 after sync and output delay
  task automatic pin(input logic [1:0] e);
    repeat (6) @(posedge clk);
    pin_q.push_back(e);
    pin_chk <= 1'b1;
    @(posedge clk);
    pin_chk <= 1'b0;
  endtask
  // Monitor compares each result with the oldest note
  always @(posedge clk) begin
    if (wb_ack_o && !wb_we_i && wb_cyc_i)
      cmp_rd(rd_q.pop_front(), wb_dat_o);
    if (pin_chk)
      cmp_pin(pin_q.pop_front(), {io_oe[0], io_out[0]});
  end
  // Watchdog
  initial begin
    #1000000;
    n_errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(32'h3000, 32'h0);
    rd(32'h3004, 32'h0);
    for (int a = 0; a < 32'h3000; a += 4)
      wb(1'b1, a, 32'h0, 4'hF);
    for (int a = 32'h4000; a < 32'h5400; a += 4)
      wb(1'b1, a, 32'h0, 4'hF);
    // Term 0 is io pin 1, terms 1..4 are x and not x
    for (int p = 0; p < 5; p++) begin
      wb(1'b1, 32'h4000 + 16 * p, 32'h1, 4'hF);
      if (p > 0)
        wb(1'b1, 32'h4004 + 16 * p, 32'h1000, 4'hF);
    end
    wb(1'b1, 32'h2000, 32'h5, 4'hF);
    for (int x = 0; x < 2; x++) begin
      wb(1'b1, 32'h0, 32'h00080000 | (x << 5), 4'hF);
      for (int v = 0; v < 2; v++) begin
        pio(v[0]);
        pin({1'b1, v[0] ^ x[0]});
      end
    end
    wb(1'b1, 32'h0, 32'h000A0000, 4'hF);
    pio(1'b1);
    pin(2'b10);
    ded(4'h1);
    pin(2'b11);
    pio(1'b0);
    pin(2'b11);
    wb(1'b1, 32'h0, 32'h000A4000, 4'hF);
    ded(4'h8);
    pin(2'b10);
    pio(1'b1);
    wb(1'b1, 32'h0, 32'h100A0000, 4'hF);
    for (int i = 0; i < 2; i++) begin
      ded(4'h1);
      pin({1'b1, ~i[0]});
    end
    sig = $random(seed);
    wb(1'b1, 32'h3000, sig, 4'hF);
    wb(1'b1, 32'h3000, ~sig, 4'h3);
    rd(32'h3000, {16'h0, sig[15:0]});
    rd(32'h7FF0, 32'h0);
    wb(1'b1, 32'h3004, 32'h1, 4'hF);
    rd(32'h3004, 32'h1);
    wb(1'b1, 32'h0, 32'h1, 4'hF);
    rd(32'h0, 32'h0);
    rd(32'h3000, {16'h0, sig[15:0]});
    complete_run;
  end
endmodule // cmf_fabric_tb_top
`default_nettype wire
